// ==== twi_bus_master_model.sv ====
/*
 * Behavioural remote bus master for the two-wire slave.
 * Assumes the bench resolves both open-drain lines with pull-ups.
 */
`timescale 1ns/1ps
module twi_bus_master_model (
	input wire logic scl_line, // Resolved SCL level
	input wire logic sda_line, // Resolved SDA level
	output logic scl_pull, // High pulls SCL low
	output logic sda_pull // High pulls SDA low
);
	// ************************************************
	// Bus conditions and bit clocking
	// ************************************************
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	task automatic start_cond();
		sda_pull = 1'b1;
		#200;
		scl_pull = 1'b1;
	endtask

	// 400 ns bit; low phase long enough for the slave to stretch first
	task automatic clock_bit(input logic b, output logic seen);
		#100;
		sda_pull = !b;
		#150;
		scl_pull = 1'b0;
		wait (scl_line === 1'b1);
		#100;
		seen = sda_line;
		#50;
		scl_pull = 1'b1;
	endtask

	// MSB first; the ninth clock samples the acknowledge
	task automatic send_bits(input logic [7:0] v, input int n,
		output logic ack);
		logic s;
		for (int i = 7; i > 7 - n; i--) clock_bit(v[i], s);
		if (n == 8) clock_bit(1'b1, ack);
	endtask

	task automatic read_byte(input logic nack, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) clock_bit(1'b1, v[i]);
		clock_bit(nack, s);
	endtask

	task automatic stop_cond();
		#100;
		sda_pull = 1'b1;
		#150;
		scl_pull = 1'b0;
		wait (scl_line === 1'b1);
		#200;
		sda_pull = 1'b0;
		#200;
	endtask
endmodule // twi_bus_master_model

// ==== twi_slave_pkg.sv ====
/*
 * Constants, state encoding and state record of the two-wire slave.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
// How it works
// - Ack select 0 pulls SDA low (ACK), 1 leaves it high (NACK).
// - Ack goes out on a command, or on a data read in smart mode.
// - Command field is a write-only strobe; 00 idles, 01 is reserved.
// - Code 10 ends a transfer: acks when direction 0, then awaits START.
// - Code 11 after an address acks, then receives or raises data flag.
// - Code 11 after a data byte acks and receives when direction 0.
// - A command clears both flags and releases SCL; new ack select first.
// - Data flag sets on a clean byte, clears by writing one, holds SCL.
// - Address/stop flag: match, collision or enabled STOP; SCL held on match.
// - Clock-hold flag is read-only and shows SCL being held low.
// - Holds the last acknowledge bit sent by the master.
// - Collision flag: lost high bit or NACK; SDA released; START clears it.
// - Bus error: repeated START or STOP off a nine-bit boundary, if enabled.
// - Direction bit copies the read/write bit of the last matched address; a status write loads it from bit 1.
// - Cause bit: 0 when STOP set the address flag, 1 for an address; a status write loads it from bit 0.
// - Own address in bits 7:1; bit 0 also accepts the general call.
// - A matching address sets the address flag and direction; promiscuous
//      mode matches every address.
// - Data buffer is reachable only while SCL is held low.
// - Master read: byte from buffer, master ack sampled, then data flag.
// - Master write: data flag and hold once a full byte is received.
// - A data buffer access accepted while SCL is held clears both flags and the clock hold.
package twi_slave_pkg;

	localparam int ADDR_W = 5;
	// Register indices; byte address is four times the index
	localparam logic [2:0] IDX_MAIN = 3'h0;
	localparam logic [2:0] IDX_CMD = 3'h1;
	localparam logic [2:0] IDX_STATUS = 3'h2;
	localparam logic [2:0] IDX_MATCH = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h4;
	localparam logic [2:0] IDX_MON = 3'h6;
	// Main control fields
	localparam int BIT_ENABLE = 3;
	localparam int BIT_STOP_EN = 2;
	localparam int BIT_PROMISC = 1;
	localparam int BIT_SMART = 0;
	// Command register fields
	localparam int BIT_ACK_SEL = 2;
	localparam logic [1:0] CMD_IDLE = 2'h0;
	localparam logic [1:0] CMD_RESERVED = 2'h1;
	localparam logic [1:0] CMD_COMPLETE = 2'h2;
	localparam logic [1:0] CMD_RESPONSE = 2'h3;
	// Status fields
	localparam int ST_DATA = 7;
	localparam int ST_ADDR_STOP = 6;
	localparam int ST_COLLISION_FLAG = 3;
	localparam int ST_BUS_ERR = 2;
	localparam logic [6:0] GENERAL_CALL = 7'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] FRAME_LAST = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Where an acknowledge bit leads
	localparam logic [1:0] AFT_IDLE = 2'h0;
	localparam logic [1:0] AFT_RX = 2'h1;
	localparam logic [1:0] AFT_DIF = 2'h2;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_RX = 6'h02,
		S_TX = 6'h04,
		S_HOLD = 6'h08,
		S_ACK_OUT = 6'h10,
		S_ACK_IN = 6'h20
	} state_t;

	typedef struct packed {
		state_t st;
		logic is_addr;
		logic [3:0] bits;
		logic [3:0] cnt9;
		logic [7:0] shreg;
		logic [7:0] data_buf;
		logic [7:0] main_ctrl;
		logic ack_sel;
		logic [7:0] own_addr;
		logic mon_en;
		logic data_flag;
		logic addr_stop_flag;
		logic hold;
		logic last_ack;
		logic collision_flag;
		logic bus_err;
		logic dir;
		logic cause;
		logic [1:0] after;
		logic sda_drive;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
	} regs_t;

	// Pin samplers start at the idle bus level, so no false edge after reset
	localparam regs_t REGS_RESET = '{st: S_IDLE, scl_s: 3'h7, sda_s: 3'h7,
		default: '0};

endpackage

// ==== two_wire_slave_control.sv ====
/*
 * Two-wire bus slave with AXI4-Lite register access.
 * Assumes open-drain SCL/SDA resolved outside; pins are asynchronous.
 */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module two_wire_slave_control import twi_slave_pkg::*; #(
	parameter int AW = ADDR_W
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, low active
	input wire logic [AW-1:0] awaddr, // Write address
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Write strobes
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [AW-1:0] araddr, // Read address
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	input wire logic scl_in, // SCL pin level
	output logic scl_out, // SCL drive value
	output logic scl_oe, // SCL pulled low while high
	input wire logic sda_in, // SDA pin level
	output logic sda_out, // SDA drive value
	output logic sda_oe // SDA pulled low while high
);

	// ****************************************
	// Checks and decode helpers
	// ****************************************
	if (AW < 5) begin : g_aw_check
		$error("AW must be at least 5");
	end

	function automatic logic reg_ok(input logic [AW-1:0] a);
		logic [2:0] i;
		i = a[4:2];
		reg_ok = (a[1:0] == 2'h0) && ((a >> 5) == '0) &&
			(i inside {IDX_MAIN, IDX_CMD, IDX_STATUS, IDX_MATCH, IDX_DATA,
			IDX_MON});
	endfunction

	regs_t r;
	regs_t n;
	logic scl, scl_p, sda, sda_p;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic wr_fire, rd_fire, wr_ok, rd_ok;
	logic [2:0] wr_idx, rd_idx;
	logic [7:0] rd_val;
	logic [7:0] rx_byte;
	logic rel, cmd_go, smart_go, go_ack, ack_eff, match;
	logic [1:0] cmd, aft;
	logic enabled;

	// ****************************************
	// Pin sampling and bus events
	// ****************************************
	assign scl = r.scl_s[1];
	assign scl_p = r.scl_s[2];
	assign sda = r.sda_s[1];
	assign sda_p = r.sda_s[2];
	assign scl_rise = scl && !scl_p;
	assign scl_fall = !scl && scl_p;
	assign start_c = scl && scl_p && sda_p && !sda;
	assign stop_c = scl && scl_p && !sda_p && sda;
	assign enabled = r.main_ctrl[BIT_ENABLE];
	assign rx_byte = {r.shreg[6:0], sda};

	// ****************************************
	// Bus handshakes
	// ****************************************
	assign wr_fire = awvalid && wvalid && !r.bvalid;
	assign awready = wr_fire;
	assign wready = wr_fire;
	assign rd_fire = arvalid && !r.rvalid;
	assign arready = rd_fire;
	assign wr_idx = awaddr[4:2];
	assign rd_idx = araddr[4:2];
	assign wr_ok = reg_ok(awaddr);
	assign rd_ok = reg_ok(araddr);
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign rvalid = r.rvalid;
	assign rresp = r.rresp;
	assign rdata = {24'h000000, r.rdata};
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = r.hold;
	assign sda_oe = r.sda_drive;

	always_comb begin
		case (rd_idx)
			IDX_MAIN: rd_val = r.main_ctrl;
			IDX_CMD: rd_val = {5'h00, r.ack_sel, 2'h0};
			IDX_STATUS: rd_val = {r.data_flag, r.addr_stop_flag, r.hold,
				r.last_ack, r.collision_flag, r.bus_err, r.dir, r.cause};
			IDX_MATCH: rd_val = r.own_addr;
			IDX_DATA: rd_val = r.data_buf;
			IDX_MON: rd_val = {7'h00, r.mon_en};
			default: rd_val = 8'h00;
		endcase
	end

	// Address match on the completed byte: promiscuous, own or general call
	assign match = r.main_ctrl[BIT_PROMISC] ||
		(r.shreg[7:1] == r.own_addr[7:1]) ||
		(r.own_addr[0] && r.shreg[7:1] == GENERAL_CALL);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n = r;
		n.scl_s = {r.scl_s[1:0], scl_in};
		n.sda_s = {r.sda_s[1:0], sda_in};
		n.bvalid = r.bvalid && !bready;
		n.rvalid = r.rvalid && !rready;
		rel = 1'b0;
		cmd_go = 1'b0;
		smart_go = 1'b0;
		go_ack = 1'b0;
		aft = AFT_IDLE;
		cmd = CMD_IDLE;
		ack_eff = r.ack_sel;
		if (wr_fire) begin
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			if (!wr_ok || (wr_idx == IDX_DATA && !r.hold)) begin
				n.bresp = RESP_SLVERR;
			end else if (wstrb[0]) begin
				case (wr_idx)
					IDX_MAIN: n.main_ctrl = wdata[7:0];
					IDX_CMD: begin
						n.ack_sel = wdata[BIT_ACK_SEL];
						ack_eff = wdata[BIT_ACK_SEL];
						cmd = wdata[1:0];
						cmd_go = wdata[1];
					end
					IDX_STATUS: begin
						n.dir = wdata[1];
						n.cause = wdata[0];
						if (wdata[ST_DATA]) n.data_flag = 1'b0;
						if (wdata[ST_ADDR_STOP]) n.addr_stop_flag = 1'b0;
						if (wdata[ST_COLLISION_FLAG]) n.collision_flag = 1'b0;
						if (wdata[ST_BUS_ERR]) n.bus_err = 1'b0;
					end
					IDX_MATCH: n.own_addr = wdata[7:0];
					IDX_DATA: begin
						n.data_buf = wdata[7:0];
						rel = 1'b1;
					end
					IDX_MON: n.mon_en = wdata[0];
					default: ;
				endcase
			end
		end
		if (rd_fire) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = rd_val;
			if (!rd_ok || (rd_idx == IDX_DATA && !r.hold)) begin
				n.rresp = RESP_SLVERR;
				n.rdata = 8'h00;
			end else if (rd_idx == IDX_DATA) begin
				rel = 1'b1;
				smart_go = r.main_ctrl[BIT_SMART] && r.data_flag && !r.dir;
			end
		end
		if (cmd_go || rel) begin
			n.data_flag = 1'b0;
			n.addr_stop_flag = 1'b0;
		end
		// Flags gone while holding: release SCL and act
		if (r.st == S_HOLD && !n.data_flag && !n.addr_stop_flag) begin
			n.hold = 1'b0;
			if (cmd_go && cmd == CMD_COMPLETE) begin
				go_ack = !r.dir;
				n.st = S_IDLE;
			end else if (cmd_go && cmd == CMD_RESPONSE && r.addr_stop_flag) begin
				go_ack = 1'b1;
				aft = r.dir ? AFT_DIF : AFT_RX;
			end else if ((cmd_go && cmd == CMD_RESPONSE && !r.dir) || smart_go) begin
				go_ack = 1'b1;
				aft = AFT_RX;
			end else if (r.dir) begin
				n.st = S_TX;
				n.shreg = n.data_buf;
				n.bits = 4'h0;
				n.sda_drive = !n.data_buf[7];
			end else begin
				n.st = S_IDLE;
			end
			if (go_ack) begin
				n.st = S_ACK_OUT;
				n.after = aft;
				n.sda_drive = !ack_eff;
			end
		end
		// Link side
		if (scl_rise && r.st != S_IDLE) begin
			n.cnt9 = (r.cnt9 == FRAME_LAST) ? 4'h0 : r.cnt9 + 4'h1;
		end
		case (r.st)
			S_RX: begin
				if (scl_rise) begin
					n.shreg = rx_byte;
					n.bits = r.bits + 4'h1;
				end else if (scl_fall && r.bits == BITS_PER_BYTE) begin
					n.bits = 4'h0;
					if (!r.is_addr) begin
						n.data_buf = r.shreg;
						n.data_flag = 1'b1;
						n.hold = 1'b1;
						n.st = S_HOLD;
					end else if (match) begin
						n.addr_stop_flag = 1'b1;
						n.cause = 1'b1;
						n.dir = r.shreg[0];
						n.data_buf = r.shreg;
						n.hold = 1'b1;
						n.st = S_HOLD;
					end else begin
						n.st = S_IDLE;
					end
				end
			end
			S_TX: begin
				if (scl_rise && !r.sda_drive && !sda) begin
					n.collision_flag = 1'b1;
					n.addr_stop_flag = 1'b1;
					n.sda_drive = 1'b0;
					n.st = S_IDLE;
				end else if (scl_fall) begin
					n.bits = r.bits + 4'h1;
					n.shreg = {r.shreg[6:0], 1'b0};
					n.sda_drive = !r.shreg[6];
					if (r.bits == BITS_PER_BYTE - 4'h1) begin
						n.sda_drive = 1'b0;
						n.st = S_ACK_IN;
					end
				end
			end
			S_ACK_IN: begin
				if (scl_rise) begin
					n.last_ack = sda;
				end else if (scl_fall) begin
					n.data_flag = 1'b1;
					n.hold = 1'b1;
					n.st = S_HOLD;
				end
			end
			S_ACK_OUT: begin
				if (scl_rise && !r.sda_drive && !sda) begin
					n.collision_flag = 1'b1;
					n.addr_stop_flag = 1'b1;
					n.st = S_IDLE;
				end else if (scl_fall) begin
					n.sda_drive = 1'b0;
					n.bits = 4'h0;
					n.is_addr = 1'b0;
					case (r.after)
						AFT_RX: n.st = S_RX;
						AFT_DIF: begin
							n.data_flag = 1'b1;
							n.hold = 1'b1;
							n.st = S_HOLD;
						end
						default: n.st = S_IDLE;
					endcase
				end
			end
			default: ;
		endcase
		if (start_c || stop_c) begin
			if (r.mon_en && r.st != S_IDLE && r.cnt9 != 4'h0) begin
				n.bus_err = 1'b1;
			end
			n.sda_drive = 1'b0;
			n.hold = 1'b0;
			n.cnt9 = 4'h0;
			n.bits = 4'h0;
			n.st = S_IDLE;
		end
		if (start_c) begin
			if (!(n.collision_flag && !r.collision_flag)) n.collision_flag = 1'b0;
			n.st = S_RX;
			n.is_addr = 1'b1;
		end
		if (stop_c && r.main_ctrl[BIT_STOP_EN]) begin
			n.addr_stop_flag = 1'b1;
			n.cause = 1'b0;
		end
		if (!enabled) begin
			n.st = S_IDLE;
			n.sda_drive = 1'b0;
			n.hold = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= REGS_RESET;
		end else begin
			r <= n;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	logic cmd_rd, data_rd_blocked, hold_cmd, stop_seen, err_cond;
	assign cmd_rd = rd_fire && rd_ok && rd_idx == IDX_CMD;
	assign data_rd_blocked = rd_fire && rd_ok && rd_idx == IDX_DATA && !r.hold;
	assign hold_cmd = wr_fire && wr_ok && wstrb[0] && wr_idx == IDX_CMD &&
		wdata[1] && r.st == S_HOLD && !stop_c;
	assign stop_seen = stop_c && enabled && r.main_ctrl[BIT_STOP_EN];
	assign err_cond = (start_c || stop_c) && r.mon_en && r.st != S_IDLE &&
		r.cnt9 != 4'h0;

	property p_ack_value;
		@(posedge aclk) disable iff (!aresetn)
		(r.st != S_ACK_OUT && n.st == S_ACK_OUT) |=> (sda_oe == !r.ack_sel);
	endproperty
	a_ack_value: assert property (p_ack_value) else $error("ack level wrong");

	property p_cmd_zero;
		@(posedge aclk) disable iff (!aresetn)
		cmd_rd |=> rvalid && rdata[1:0] == 2'h0;
	endproperty
	a_cmd_zero: assert property (p_cmd_zero) else $error("command reads nonzero");

	property p_cmd_release;
		@(posedge aclk) disable iff (!aresetn)
		hold_cmd |=> !scl_oe && !r.data_flag && !r.addr_stop_flag;
	endproperty
	a_cmd_release: assert property (p_cmd_release) else $error("command kept hold");

	property p_data_hold;
		@(posedge aclk) disable iff (!aresetn)
		$rose(r.data_flag) |-> scl_oe;
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data flag without hold");

	property p_hold_flags;
		@(posedge aclk) disable iff (!aresetn)
		scl_oe |-> r.data_flag || r.addr_stop_flag;
	endproperty
	a_hold_flags: assert property (p_hold_flags) else $error("hold without flag");

	property p_collision_flag_quiet;
		@(posedge aclk) disable iff (!aresetn)
		$rose(r.collision_flag) |-> !sda_oe [*3];
	endproperty
	a_collision_flag_quiet: assert property (p_collision_flag_quiet) else $error("SDA driven after collision");

	property p_bus_err;
		@(posedge aclk) disable iff (!aresetn)
		err_cond |=> r.bus_err;
	endproperty
	a_bus_err: assert property (p_bus_err) else $error("bus error missed");

	property p_stop_cause;
		@(posedge aclk) disable iff (!aresetn)
		stop_seen |=> r.addr_stop_flag && !r.cause && !scl_oe;
	endproperty
	a_stop_cause: assert property (p_stop_cause) else $error("stop cause wrong");

	property p_blocked;
		@(posedge aclk) disable iff (!aresetn)
		data_rd_blocked |=> rresp == RESP_SLVERR;
	endproperty
	a_blocked: assert property (p_blocked) else $error("data read not blocked");

	c_addr: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(r.addr_stop_flag) && r.cause);
	c_tx_done: cover property (@(posedge aclk) disable iff (!aresetn)
		r.st == S_ACK_IN && scl_fall);
	c_rx_byte: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(r.data_flag) && !r.dir);

endmodule // two_wire_slave_control

// ==== two_wire_slave_control_test.sv ====
/*
 * Self-checking bench for the two-wire slave: register bus plus master.
 * Assumes the package constants and the hand-over timing of the design.
 */
`timescale 1ns/1ps
module two_wire_slave_control_test;
	import twi_slave_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [4:0] awaddr = 5'h00;
	logic [4:0] araddr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe;
	logic m_scl, m_sda, scl_line, sda_line;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] lfsr = 8'h15;
	logic [7:0] q[$];
	int fail_count = 0;
	int check_count = 0;
	assign scl_line = !(scl_oe | m_scl);
	assign sda_line = !(sda_oe | m_sda);
	always #25 aclk = ~aclk;

	two_wire_slave_control two_wire_slave_control_i (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.scl_in(scl_line), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_line),
		.sda_out(), .sda_oe(sda_oe));
	twi_bus_master_model twi_bus_master_model_i (.scl_line(scl_line),
		.sda_line(sda_line), .scl_pull(m_scl), .sda_pull(m_sda));

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic [7:0] next_rand(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(logic [2:0] idx, logic [7:0] v, logic [1:0] er);
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(negedge aclk);
		while (!(awready === 1'b1 && wready === 1'b1)) @(negedge aclk);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(negedge aclk);
		while (bvalid !== 1'b1) @(negedge aclk);
		chk("bresp", {6'h0, er}, {6'h0, bresp});
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(string n, logic [2:0] idx, logic [7:0] e,
		logic [1:0] er);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge aclk);
		while (arready !== 1'b1) @(negedge aclk);
		@(posedge aclk);
		arvalid <= 1'b0;
		@(negedge aclk);
		while (rvalid !== 1'b1) @(negedge aclk);
		chk(n, e, rdata[7:0]);
		chk("rresp", {6'h0, er}, {6'h0, rresp});
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	task automatic hold();
		@(negedge aclk);
		while (scl_oe !== 1'b1) @(negedge aclk);
		repeat (2) @(posedge aclk);
	endtask

	task automatic stop();
		twi_bus_master_model_i.stop_cond();
		repeat (8) @(posedge aclk);
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		final_report();
	end

	// ************************************************
	// Scenarios
	// ************************************************
	initial begin
		logic ack;
		logic [7:0] b;
		logic [7:0] v;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd("status", IDX_STATUS, 8'h00, RESP_OKAY);
		rd("unmapped", 3'h5, 8'h00, RESP_SLVERR);
		rd("data", IDX_DATA, 8'h00, RESP_SLVERR);
		wr(IDX_MATCH, 8'h52, RESP_OKAY);
		wr(IDX_MAIN, 8'h0D, RESP_OKAY);
		twi_bus_master_model_i.start_cond();
		fork
			twi_bus_master_model_i.send_bits(8'h52, 8, ack);
			begin
				hold();
				rd("status", IDX_STATUS, 8'h61, RESP_OKAY);
				wr(IDX_CMD, 8'h03, RESP_OKAY);
			end
		join
		chk("addr ack", 8'h00, {7'h0, ack});
		rd("status", IDX_STATUS, 8'h01, RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			b = lfsr;
			lfsr = next_rand(lfsr);
			q.push_back(b);
			fork
				twi_bus_master_model_i.send_bits(b, 8, ack);
				begin
					hold();
					rd("status", IDX_STATUS, 8'hA1, RESP_OKAY);
					if (k == 1) begin
						wr(IDX_CMD, 8'h04, RESP_OKAY);
						rd("status", IDX_STATUS, 8'hA1, RESP_OKAY);
					end
					rd("data", IDX_DATA, q.pop_front(), RESP_OKAY);
				end
			join
			chk("data ack", 8'(k), {7'h0, ack});
			rd("status", IDX_STATUS, 8'h01, RESP_OKAY);
		end
		rd("cmd", IDX_CMD, 8'h04, RESP_OKAY);
		stop();
		rd("status", IDX_STATUS, 8'h40, RESP_OKAY);
		wr(IDX_STATUS, 8'h40, RESP_OKAY);
		rd("status", IDX_STATUS, 8'h00, RESP_OKAY);
		twi_bus_master_model_i.start_cond();
		fork
			twi_bus_master_model_i.send_bits(8'h53, 8, ack);
			begin
				hold();
				rd("status", IDX_STATUS, 8'h63, RESP_OKAY);
				wr(IDX_CMD, 8'h03, RESP_OKAY);
				hold();
				rd("status", IDX_STATUS, 8'hA3, RESP_OKAY);
			end
		join
		for (int k = 0; k < 2; k++) begin
			b = lfsr;
			lfsr = next_rand(lfsr);
			fork
				twi_bus_master_model_i.read_byte(k[0], v);
				begin
					wr(IDX_DATA, b, RESP_OKAY);
					hold();
					rd("status", IDX_STATUS, 8'hA3 | 8'(k * 16),
						RESP_OKAY);
				end
			join
			chk("tx byte", b, v);
		end
		wr(IDX_CMD, 8'h02, RESP_OKAY);
		rd("status", IDX_STATUS, 8'h13, RESP_OKAY);
		stop();
		rd("status", IDX_STATUS, 8'h52, RESP_OKAY);
		wr(IDX_STATUS, 8'h40, RESP_OKAY);
		wr(IDX_MAIN, 8'h09, RESP_OKAY);
		twi_bus_master_model_i.start_cond();
		twi_bus_master_model_i.send_bits(8'h20, 8, ack);
		chk("no match ack", 8'h01, {7'h0, ack});
		stop();
		rd("status", IDX_STATUS, 8'h10, RESP_OKAY);
		wr(IDX_MAIN, 8'h0B, RESP_OKAY);
		twi_bus_master_model_i.start_cond();
		fork
			twi_bus_master_model_i.send_bits(8'h20, 8, ack);
			begin
				hold();
				rd("status", IDX_STATUS, 8'h71, RESP_OKAY);
				wr(IDX_CMD, 8'h02, RESP_OKAY);
			end
		join
		chk("promisc ack", 8'h00, {7'h0, ack});
		twi_bus_master_model_i.send_bits(lfsr, 8, ack);
		chk("after complete", 8'h01, {7'h0, ack});
		stop();
		wr(IDX_MAIN, 8'h09, RESP_OKAY);
		wr(IDX_MATCH, 8'h53, RESP_OKAY);
		twi_bus_master_model_i.start_cond();
		fork
			twi_bus_master_model_i.send_bits(8'h00, 8, ack);
			begin
				hold();
				rd("status", IDX_STATUS, 8'h71, RESP_OKAY);
				wr(IDX_CMD, 8'h06, RESP_OKAY);
			end
		join
		chk("call nack", 8'h01, {7'h0, ack});
		stop();
		wr(IDX_MON, 8'h01, RESP_OKAY);
		twi_bus_master_model_i.start_cond();
		twi_bus_master_model_i.send_bits(8'hA5, 3, ack);
		stop();
		rd("status", IDX_STATUS, 8'h15, RESP_OKAY);
		wr(IDX_STATUS, 8'h04, RESP_OKAY);
		rd("status", IDX_STATUS, 8'h10, RESP_OKAY);
		final_report();
	end
endmodule // two_wire_slave_control_test
